// ==== als_params.svh ====
`ifndef ALS_PARAMS_SVH
`define ALS_PARAMS_SVH

// Clock and timing
`define ALS_CLK_HZ 10000000
`define ALS_CYC_PER_MS (`ALS_CLK_HZ / 1000)
`define ALS_INT_SHORT_MS 100
`define ALS_INT_LONG_MS 800
`define ALS_ASSESS_MS 10
`define ALS_SETTLE_MS 3
`define ALS_TIMEOUT_MS 28

// Widths
`define ALS_CNT_W 24
`define ALS_DATA_W 16

// Register offsets
`define ALS_REG_CONFIG 3'h0
`define ALS_REG_RESULT 3'h1
`define ALS_REG_LOWLIM 3'h2
`define ALS_REG_HIGHLIM 3'h3
`define ALS_REG_STATUS 3'h4
`define ALS_REG_INTCLR 3'h5
`define ALS_REG_INTEN 3'h6

// Config fields
`define ALS_CFG_MODE 1:0
`define ALS_CFG_CONV_TIME 2
`define ALS_CFG_RANGE 6:3

// Status and interrupt bits
`define ALS_ST_DONE 0
`define ALS_ST_HIGH 1
`define ALS_ST_LOW 2
`define ALS_ST_TOUT 3

// Codes and reset values
`define ALS_MODE_SHUT 2'h0
`define ALS_MODE_SINGLE 2'h1
`define ALS_RANGE_AUTO 4'hC
`define ALS_RANGE_RESET 4'hC
`define ALS_HIGHLIM_RESET 16'hFFFF
`define ALS_DEV_ADDR 7'h2A
`define ALS_RANGE_MAX 4'hB

`endif

// ==== als_pkg.sv ====
`include "als_params.svh"

package als_pkg;

    typedef enum logic [1:0] {
        CV_IDLE = 2'b00,
        CV_ASSESS = 2'b01,
        CV_INTEG = 2'b10,
        CV_SETTLE = 2'b11
    } als_phase_t;

    typedef enum logic [2:0] {
        I2_IDLE = 3'b000,
        I2_ADDR = 3'b001,
        I2_ACKA = 3'b010,
        I2_TX = 3'b011,
        I2_TXACK = 3'b100,
        I2_RX = 3'b101,
        I2_RXACK = 3'b110
    } als_i2c_t;

    typedef struct packed {
        logic [1:0] mode;
        logic convTimeSel;
        logic [3:0] rangeField;
        logic [`ALS_DATA_W-1:0] lowLim;
        logic [`ALS_DATA_W-1:0] highLim;
        logic [`ALS_DATA_W-1:0] result;
        logic [3:0] intEn;
        logic [3:0] status;
        logic [`ALS_DATA_W-1:0] rdData;
        als_phase_t phase;
        logic [`ALS_CNT_W-1:0] cnt;
        logic convTimeLat;
        logic assessed;
        logic [3:0] rangeSel;
        logic alertLow;
        logic doneEvt;
        logic sclPrev;
        logic sdaPrev;
        als_i2c_t i2c;
        logic rw;
        logic [3:0] bitCnt;
        logic [7:0] shReg;
        logic sdaLow;
        logic ackSeen;
        logic byteSel;
        logic [`ALS_DATA_W-1:0] txHold;
        logic [`ALS_CNT_W-1:0] sclLowCnt;
    } als_state_t;

endpackage : als_pkg

// ==== als_sync.sv ====
module als_sync (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Line
    input wire logic asyncIn,
    output logic syncOut
);
    logic stage1_r;
    logic stage2_r;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            stage1_r <= 1'b1;
            stage2_r <= 1'b1;
        end else begin
            stage1_r <= asyncIn;
            stage2_r <= stage1_r;
        end
    end

    assign syncOut = stage2_r;
endmodule : als_sync

// ==== als_ctrl.sv ====
// The address-and-strobe port and the placing of the registers were left to the implementer.
`include "als_params.svh"

// Behaviour
// - Reset the serial state machine when SCL stays low for 28 ms.
// - Integrate each measurement over 100 ms or 800 ms.
// - Conversion time select 1 gives 800 ms integration.
// - Range field 1100b selects automatic full-scale range.
// - Start in shutdown; measure only after host writes an active mode.
// - Support continuous and single-shot modes chosen by the host.
// - Compare each result with a window; show outcome on the alert pin.
// - Completed result readable in lux over the two-wire interface.
// - Mode field 00 means shutdown with no conversions.
// - Result readable no earlier than integration plus 3 ms.
// - In auto range first do a 10 ms assessment, then full measurement.
module als_ctrl #(
    parameter logic [`ALS_CNT_W-1:0] SHORT_CYC = `ALS_CNT_W'(`ALS_CYC_PER_MS * `ALS_INT_SHORT_MS),
    parameter logic [`ALS_CNT_W-1:0] LONG_CYC = `ALS_CNT_W'(`ALS_CYC_PER_MS * `ALS_INT_LONG_MS),
    parameter logic [`ALS_CNT_W-1:0] ASSESS_CYC = `ALS_CNT_W'(`ALS_CYC_PER_MS * `ALS_ASSESS_MS),
    parameter logic [`ALS_CNT_W-1:0] SETTLE_CYC = `ALS_CNT_W'(`ALS_CYC_PER_MS * `ALS_SETTLE_MS),
    parameter logic [`ALS_CNT_W-1:0] TIMEOUT_CYC = `ALS_CNT_W'(`ALS_CYC_PER_MS * `ALS_TIMEOUT_MS)
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Register port
    input wire logic [2:0] regAddr,
    input wire logic [`ALS_DATA_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [`ALS_DATA_W-1:0] regRdData,
    // Measurement front end
    input wire logic [`ALS_DATA_W-1:0] adcCode,
    output logic integEn,
    output logic [3:0] rangeSel,
    output logic convBusy,
    // Serial bus pins
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOeN,
    // Alert pin and interrupt
    output logic alertOut,
    output logic alertOeN,
    output logic irq
);
    als_pkg::als_state_t s_r;
    als_pkg::als_state_t s_nxt;
    logic scl;
    logic sda;
    logic sclRise;
    logic sclFall;
    logic busStart;
    logic busStop;
    logic cfgWr;
    logic [3:0] evt;
    logic [3:0] clr;
    logic [7:0] nextByte;

    als_sync u_scl_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .asyncIn(sclIn),
        .syncOut(scl)
    );

    als_sync u_sda_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .asyncIn(sdaIn),
        .syncOut(sda)
    );

    // Range choice from the assessment code
    function automatic logic [3:0] pickRange(input logic [`ALS_DATA_W-1:0] code);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 4; i < `ALS_DATA_W; i++) begin
            if (code[i]) begin
                r = 4'(i - 4);
            end
        end
        if (r > `ALS_RANGE_MAX) begin
            r = `ALS_RANGE_MAX;
        end
        return r;
    endfunction : pickRange

    assign sclRise = scl && !s_r.sclPrev;
    assign sclFall = !scl && s_r.sclPrev;
    assign busStart = scl && s_r.sclPrev && s_r.sdaPrev && !sda;
    assign busStop = scl && s_r.sclPrev && !s_r.sdaPrev && sda;
    assign cfgWr = regWr && (regAddr == `ALS_REG_CONFIG);
    assign nextByte = s_r.byteSel ? s_r.txHold[15:8] : s_r.txHold[7:0];

    always_comb begin
        s_nxt = s_r;
        s_nxt.doneEvt = 1'b0;
        s_nxt.sclPrev = scl;
        s_nxt.sdaPrev = sda;
        evt = 4'h0;
        clr = 4'h0;

        // Register writes
        if (regWr) begin
            unique case (regAddr)
                `ALS_REG_CONFIG: begin
                    s_nxt.mode = regWrData[`ALS_CFG_MODE];
                    s_nxt.convTimeSel = regWrData[`ALS_CFG_CONV_TIME];
                    s_nxt.rangeField = regWrData[`ALS_CFG_RANGE];
                end
                `ALS_REG_LOWLIM: s_nxt.lowLim = regWrData;
                `ALS_REG_HIGHLIM: s_nxt.highLim = regWrData;
                `ALS_REG_INTCLR: clr = regWrData[3:0];
                `ALS_REG_INTEN: s_nxt.intEn = regWrData[3:0];
                default: ;
            endcase
        end

        // Register reads, one cycle later
        s_nxt.rdData = '0;
        if (regRd) begin
            unique case (regAddr)
                `ALS_REG_CONFIG: begin
                    s_nxt.rdData = `ALS_DATA_W'({s_r.rangeField, s_r.convTimeSel, s_r.mode});
                end
                `ALS_REG_RESULT: s_nxt.rdData = s_r.result;
                `ALS_REG_LOWLIM: s_nxt.rdData = s_r.lowLim;
                `ALS_REG_HIGHLIM: s_nxt.rdData = s_r.highLim;
                `ALS_REG_STATUS: s_nxt.rdData = `ALS_DATA_W'(s_r.status);
                `ALS_REG_INTEN: s_nxt.rdData = `ALS_DATA_W'(s_r.intEn);
                default: s_nxt.rdData = '0;
            endcase
        end

        unique case (s_r.phase)
            als_pkg::CV_IDLE: begin
                if (s_r.mode != `ALS_MODE_SHUT) begin
                    s_nxt.convTimeLat = s_r.convTimeSel;
                    if (s_r.rangeField == `ALS_RANGE_AUTO && !s_r.assessed) begin
                        s_nxt.phase = als_pkg::CV_ASSESS;
                        s_nxt.cnt = ASSESS_CYC - 1'b1;
                    end else begin
                        s_nxt.phase = als_pkg::CV_INTEG;
                        s_nxt.cnt = (s_r.convTimeSel ? LONG_CYC : SHORT_CYC) - 1'b1;
                        if (s_r.rangeField != `ALS_RANGE_AUTO) begin
                            s_nxt.rangeSel = s_r.rangeField;
                        end
                    end
                end
            end
            als_pkg::CV_ASSESS: begin
                if (s_r.cnt == '0) begin
                    s_nxt.rangeSel = pickRange(adcCode);
                    s_nxt.assessed = 1'b1;
                    s_nxt.phase = als_pkg::CV_INTEG;
                    s_nxt.cnt = (s_r.convTimeLat ? LONG_CYC : SHORT_CYC) - 1'b1;
                end else begin
                    s_nxt.cnt = s_r.cnt - 1'b1;
                end
            end
            als_pkg::CV_INTEG: begin
                if (s_r.cnt == '0) begin
                    s_nxt.phase = als_pkg::CV_SETTLE;
                    s_nxt.cnt = SETTLE_CYC - 1'b1;
                end else begin
                    s_nxt.cnt = s_r.cnt - 1'b1;
                end
            end
            als_pkg::CV_SETTLE: begin
                if (s_r.cnt == '0) begin
                    s_nxt.result = adcCode;
                    s_nxt.doneEvt = 1'b1;
                    s_nxt.phase = als_pkg::CV_IDLE;
                    evt[`ALS_ST_DONE] = 1'b1;
                    evt[`ALS_ST_HIGH] = adcCode > s_r.highLim;
                    evt[`ALS_ST_LOW] = adcCode < s_r.lowLim;
                    if (s_r.mode == `ALS_MODE_SINGLE && !cfgWr) begin
                        s_nxt.mode = `ALS_MODE_SHUT;
                    end
                end else begin
                    s_nxt.cnt = s_r.cnt - 1'b1;
                end
            end
        endcase

        if (s_r.mode == `ALS_MODE_SHUT) begin
            s_nxt.phase = als_pkg::CV_IDLE;
            s_nxt.assessed = 1'b0;
            s_nxt.cnt = '0;
        end

        s_nxt.alertLow = (s_r.result > s_r.highLim) || (s_r.result < s_r.lowLim);

        if (busStart) begin
            s_nxt.i2c = als_pkg::I2_ADDR;
            s_nxt.bitCnt = 4'h0;
            s_nxt.sdaLow = 1'b0;
        end else if (busStop) begin
            s_nxt.i2c = als_pkg::I2_IDLE;
            s_nxt.sdaLow = 1'b0;
        end else begin
            unique case (s_r.i2c)
                als_pkg::I2_IDLE: ;
                als_pkg::I2_ADDR: begin
                    if (sclRise) begin
                        s_nxt.shReg = {s_r.shReg[6:0], sda};
                        s_nxt.bitCnt = s_r.bitCnt + 4'h1;
                    end else if (sclFall && s_r.bitCnt == 4'h8) begin
                        if (s_r.shReg[7:1] == `ALS_DEV_ADDR) begin
                            s_nxt.i2c = als_pkg::I2_ACKA;
                            s_nxt.rw = s_r.shReg[0];
                            s_nxt.sdaLow = 1'b1;
                        end else begin
                            s_nxt.i2c = als_pkg::I2_IDLE;
                        end
                    end
                end
                als_pkg::I2_ACKA: begin
                    if (sclFall) begin
                        s_nxt.bitCnt = s_r.rw ? 4'h1 : 4'h0;
                        if (s_r.rw) begin
                            s_nxt.i2c = als_pkg::I2_TX;
                            s_nxt.txHold = s_r.result;
                            s_nxt.byteSel = 1'b0;
                            s_nxt.sdaLow = !s_r.result[15];
                            s_nxt.shReg = {s_r.result[14:8], 1'b0};
                        end else begin
                            s_nxt.i2c = als_pkg::I2_RX;
                            s_nxt.sdaLow = 1'b0;
                        end
                    end
                end
                als_pkg::I2_TX: begin
                    if (sclFall) begin
                        if (s_r.bitCnt == 4'h8) begin
                            s_nxt.i2c = als_pkg::I2_TXACK;
                            s_nxt.sdaLow = 1'b0;
                        end else begin
                            s_nxt.sdaLow = !s_r.shReg[7];
                            s_nxt.shReg = {s_r.shReg[6:0], 1'b0};
                            s_nxt.bitCnt = s_r.bitCnt + 4'h1;
                        end
                    end
                end
                als_pkg::I2_TXACK: begin
                    if (sclRise) begin
                        s_nxt.ackSeen = !sda;
                    end else if (sclFall) begin
                        if (s_r.ackSeen) begin
                            s_nxt.i2c = als_pkg::I2_TX;
                            s_nxt.byteSel = !s_r.byteSel;
                            s_nxt.sdaLow = !nextByte[7];
                            s_nxt.shReg = {nextByte[6:0], 1'b0};
                            s_nxt.bitCnt = 4'h1;
                        end else begin
                            s_nxt.i2c = als_pkg::I2_IDLE;
                        end
                    end
                end
                als_pkg::I2_RX: begin
                    if (sclRise) begin
                        s_nxt.bitCnt = s_r.bitCnt + 4'h1;
                    end else if (sclFall && s_r.bitCnt == 4'h8) begin
                        s_nxt.i2c = als_pkg::I2_RXACK;
                        s_nxt.sdaLow = 1'b1;
                    end
                end
                als_pkg::I2_RXACK: begin
                    if (sclFall) begin
                        s_nxt.i2c = als_pkg::I2_RX;
                        s_nxt.sdaLow = 1'b0;
                        s_nxt.bitCnt = 4'h0;
                    end
                end
                default: s_nxt.i2c = als_pkg::I2_IDLE;
            endcase
        end

        if (scl) begin
            s_nxt.sclLowCnt = '0;
        end else if (s_r.sclLowCnt == TIMEOUT_CYC - 1'b1) begin
            s_nxt.sclLowCnt = '0;
            s_nxt.i2c = als_pkg::I2_IDLE;
            s_nxt.sdaLow = 1'b0;
            evt[`ALS_ST_TOUT] = 1'b1;
        end else begin
            s_nxt.sclLowCnt = s_r.sclLowCnt + 1'b1;
        end

        // Sticky status, set beats clear
        s_nxt.status = (s_r.status & ~clr) | evt;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s_r <= '0;
            s_r.rangeField <= `ALS_RANGE_RESET;
            s_r.highLim <= `ALS_HIGHLIM_RESET;
            s_r.sclPrev <= 1'b1;
            s_r.sdaPrev <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign regRdData = s_r.rdData;
    assign integEn = (s_r.phase == als_pkg::CV_ASSESS) || (s_r.phase == als_pkg::CV_INTEG);
    assign rangeSel = s_r.rangeSel;
    assign convBusy = s_r.phase != als_pkg::CV_IDLE;
    assign sdaOut = 1'b0;
    assign sdaOeN = !s_r.sdaLow;
    assign alertOut = 1'b0;
    assign alertOeN = !s_r.alertLow;
    assign irq = |(s_r.status & s_r.intEn);

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    sequence enterInteg;
        s_r.phase != als_pkg::CV_INTEG ##1 s_r.phase == als_pkg::CV_INTEG;
    endsequence

    sequence enterSettle;
        s_r.phase != als_pkg::CV_SETTLE ##1 s_r.phase == als_pkg::CV_SETTLE;
    endsequence

    sequence convEnd;
        s_r.phase == als_pkg::CV_SETTLE && s_r.cnt == '0;
    endsequence

    a_boot_shutdown: assert property ($past(sys_rst) |-> s_r.mode == `ALS_MODE_SHUT && !convBusy)
        else $error("not in shutdown after reset");
    a_shut_idle: assert property (s_r.mode == `ALS_MODE_SHUT |=> s_r.phase == als_pkg::CV_IDLE)
        else $error("conversion running in shutdown");
    a_long_period: assert property (enterInteg ##0 s_r.convTimeLat
        |-> s_r.cnt == LONG_CYC - 1'b1)
        else $error("long integration count wrong");
    a_short_period: assert property (enterInteg ##0 !s_r.convTimeLat
        |-> s_r.cnt == SHORT_CYC - 1'b1)
        else $error("short integration count wrong");
    a_settle_wait: assert property (enterSettle |-> s_r.cnt == SETTLE_CYC - 1'b1)
        else $error("settle count wrong");
    a_auto_assess: assert property (s_r.phase == als_pkg::CV_IDLE && s_r.mode != `ALS_MODE_SHUT
        && s_r.rangeField == `ALS_RANGE_AUTO && !s_r.assessed
        |=> s_r.phase == als_pkg::CV_ASSESS && s_r.cnt == ASSESS_CYC - 1'b1)
        else $error("auto range did not assess first");
    a_result_hold: assert property (!convEnd |=> $stable(s_r.result))
        else $error("result changed mid conversion");
    a_single_stop: assert property (convEnd ##0 s_r.mode == `ALS_MODE_SINGLE && !cfgWr
        |=> s_r.mode == `ALS_MODE_SHUT ##1 !convBusy)
        else $error("single shot did not stop");
    a_cont_repeat: assert property (convEnd ##0 s_r.mode[1] && !regWr
        |=> ##1 s_r.phase == als_pkg::CV_INTEG)
        else $error("continuous mode did not restart");
    a_alert_window: assert property (s_r.result > s_r.highLim || s_r.result < s_r.lowLim
        |=> !alertOeN)
        else $error("alert not driven outside window");
    a_bus_timeout: assert property (!scl && s_r.sclLowCnt == TIMEOUT_CYC - 1'b1
        |=> s_r.i2c == als_pkg::I2_IDLE && sdaOeN && s_r.status[`ALS_ST_TOUT])
        else $error("bus timeout did not reset");
    a_tx_snapshot: assert property (s_r.i2c == als_pkg::I2_ACKA && s_r.rw && sclFall && !busStop
        && !(!scl && s_r.sclLowCnt == TIMEOUT_CYC - 1'b1)
        |=> s_r.txHold == $past(s_r.result) && s_r.i2c == als_pkg::I2_TX)
        else $error("read did not load result");
endmodule : als_ctrl

// ==== als_i2c_master.sv ====
module als_i2c_master (
    // Bus lines
    output logic scl,
    output logic sdaPullLow,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle bus: both lines released to their pull-ups
    initial begin
        scl = 1'b1;
        sdaPullLow = 1'b0;
    end

    task automatic sendBit(input logic b);
        sdaPullLow = ~b;
        #200;
        scl = 1'b1;
        #400;
        scl = 1'b0;
        #200;
    endtask : sendBit

    task automatic recvBit(output logic b);
        sdaPullLow = 1'b0;
        #200;
        scl = 1'b1;
        #200;
        b = sda;
        #200;
        scl = 1'b0;
        #200;
    endtask : recvBit

    // Start, then address with read direction; SCL is left low
    task automatic startAddr(input logic [6:0] addr, output logic ack);
        logic [7:0] byteOut;
        byteOut = {addr, 1'b1};
        sdaPullLow = 1'b1;
        #400;
        scl = 1'b0;
        #200;
        for (int i = 7; i >= 0; i--) begin
            sendBit(byteOut[i]);
        end
        recvBit(ack);
    endtask : startAddr

    task automatic holdScl(input int ns);
        #ns;
    endtask : holdScl

    task automatic stopCond();
        sdaPullLow = 1'b1;
        #200;
        scl = 1'b1;
        #400;
        sdaPullLow = 1'b0;
        #800;
    endtask : stopCond

    // Two-byte read: acknowledge the first byte, refuse the second
    task automatic readWord(input logic [6:0] addr, output logic ack, output logic [15:0] data);
        logic b;
        data = 16'h0000;
        startAddr(addr, ack);
        if (ack === 1'b0) begin
            for (int i = 15; i >= 0; i--) begin
                recvBit(b);
                data[i] = b;
                if (i == 8) begin
                    sendBit(1'b0);
                end
            end
            sendBit(1'b1);
        end
        stopCond();
    endtask : readWord
endmodule : als_i2c_master

// ==== als_ctrl_test.sv ====
`include "als_params.svh"

module als_ctrl_test;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [`ALS_CNT_W-1:0] SHORT = 24'h0000C8;
    localparam logic [`ALS_CNT_W-1:0] LONG = 24'h000190;
    localparam logic [`ALS_CNT_W-1:0] ASSESS = 24'h000032;
    localparam logic [`ALS_CNT_W-1:0] SETTLE = 24'h00001E;
    localparam logic [`ALS_CNT_W-1:0] TOUT = 24'h00012C;

    logic mclk, sys_rst, regWr, regRd, integEn, convBusy;
    logic [2:0] regAddr;
    logic [15:0] regWrData, regRdData, adcCode;
    logic [3:0] rangeSel;
    logic scl, sdaPullLow, sdaLine, sdaOut, sdaOeN, alertOut, alertOeN, irq;
    int errTotal = 0;
    int samplesChecked = 0;
    int cycleCount = 0;

    // Open-drain data line with pull-up
    assign sdaLine = (sdaPullLow || !sdaOeN) ? 1'b0 : 1'b1;

    als_ctrl #(.SHORT_CYC(SHORT), .LONG_CYC(LONG), .ASSESS_CYC(ASSESS),
        .SETTLE_CYC(SETTLE), .TIMEOUT_CYC(TOUT)) u_als_ctrl (
        .mclk(mclk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .adcCode(adcCode),
        .integEn(integEn), .rangeSel(rangeSel), .convBusy(convBusy), .sclIn(scl),
        .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .alertOut(alertOut),
        .alertOeN(alertOeN), .irq(irq));

    als_i2c_master u_als_i2c_master (.scl(scl), .sdaPullLow(sdaPullLow), .sda(sdaLine));

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic endSim();
        if (errTotal == 0 && samplesChecked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : endSim

    always @(posedge mclk) begin
        cycleCount++;
        if (cycleCount == 30000) begin
            errTotal++;
            endSim();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            errTotal++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    function automatic logic [15:0] cfgWord(input logic [1:0] m, input logic c, input logic [3:0] r);
        return {9'h000, r, c, m};
    endfunction : cfgWord

    task automatic regWrite(input logic [2:0] a, input logic [15:0] d);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
        @(posedge mclk);
    endtask : regWrite

    task automatic regRead(input logic [2:0] a, output logic [15:0] d);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        #1 d = regRdData;
        @(posedge mclk);
    endtask : regRead

    // Counts integrating and busy cycles of one conversion
    task automatic measure(output int ic, output int bc);
        int g;
        ic = 0;
        bc = 0;
        g = 0;
        @(negedge mclk);
        while (convBusy !== 1'b1 && g < 20) begin
            @(negedge mclk);
            g++;
        end
        while (convBusy === 1'b1 && bc < 2000) begin
            ic += (integEn === 1'b1);
            bc++;
            @(negedge mclk);
        end
        @(posedge mclk);
    endtask : measure

    task automatic idleCheck();
        int c;
        c = 0;
        repeat (300) begin
            @(negedge mclk);
            c += (integEn === 1'b1 || convBusy === 1'b1);
        end
        @(posedge mclk);
        check(16'(c), 16'h0000);
    endtask : idleCheck

    task automatic resetState();
        logic [15:0] d;
        regRead(`ALS_REG_CONFIG, d);
        check(d, cfgWord(2'h0, 1'b0, 4'hC));
        regRead(3'h7, d);
        check(d, 16'h0000);
        idleCheck();
    endtask : resetState

    task automatic fixedRuns();
        int ic, bc;
        logic [15:0] d;
        logic ack;
        regWrite(`ALS_REG_CONFIG, cfgWord(2'h1, 1'b0, 4'h3));
        measure(ic, bc);
        check(16'(ic), SHORT[15:0]);
        check(16'(bc), 16'(SHORT + SETTLE));
        check(16'(rangeSel), 16'h0003);
        regRead(`ALS_REG_CONFIG, d);
        check(d, cfgWord(2'h0, 1'b0, 4'h3));
        regRead(`ALS_REG_RESULT, d);
        check(d, 16'h1234);
        u_als_i2c_master.readWord(`ALS_DEV_ADDR, ack, d);
        check({15'h0, ack}, 16'h0000);
        check(d, 16'h1234);
        u_als_i2c_master.readWord(7'h2B, ack, d);
        check({15'h0, ack}, 16'h0001);
        @(posedge mclk);
        adcCode <= 16'h5678;
        regWrite(`ALS_REG_CONFIG, cfgWord(2'h1, 1'b1, 4'h3));
        fork
            measure(ic, bc);
            begin
                repeat (100) @(posedge mclk);
                regRead(`ALS_REG_RESULT, d);
                check(d, 16'h1234);
            end
        join
        check(16'(ic), LONG[15:0]);
    endtask : fixedRuns

    task automatic autoRuns();
        int ic, bc;
        adcCode <= 16'h0400;
        regWrite(`ALS_REG_CONFIG, cfgWord(2'h2, 1'b0, 4'hC));
        measure(ic, bc);
        check(16'(ic), 16'(ASSESS + SHORT));
        // Top set bit 10, minus 4
        check(16'(rangeSel), 16'h0006);
        measure(ic, bc);
        check(16'(ic), SHORT[15:0]);
        regWrite(`ALS_REG_CONFIG, cfgWord(2'h0, 1'b0, 4'hC));
        @(posedge mclk);
        idleCheck();
    endtask : autoRuns

    task automatic windowCase(input logic [15:0] code, input logic [15:0] st, input logic a);
        int ic, bc;
        logic [15:0] d;
        regWrite(`ALS_REG_INTCLR, 16'h000F);
        adcCode <= code;
        regWrite(`ALS_REG_CONFIG, cfgWord(2'h1, 1'b0, 4'h3));
        measure(ic, bc);
        repeat (2) @(posedge mclk);
        check({15'h0, alertOeN}, {15'h0, a});
        regRead(`ALS_REG_STATUS, d);
        check(d, st);
    endtask : windowCase

    task automatic irqWrite(input logic [2:0] a, input logic [15:0] d, input logic e);
        regWrite(a, d);
        @(negedge mclk);
        check({15'h0, irq}, {15'h0, e});
        @(posedge mclk);
    endtask : irqWrite

    task automatic windowRuns();
        regWrite(`ALS_REG_LOWLIM, 16'h0100);
        irqWrite(`ALS_REG_HIGHLIM, 16'h1000, 1'b0);
        regWrite(`ALS_REG_INTEN, 16'h0003);
        windowCase(16'h2000, 16'h0003, 1'b0);
        irqWrite(`ALS_REG_INTEN, 16'h0000, 1'b0);
        irqWrite(`ALS_REG_INTEN, 16'h0003, 1'b1);
        irqWrite(`ALS_REG_INTCLR, 16'h0003, 1'b0);
        windowCase(16'h0050, 16'h0005, 1'b0);
        windowCase(16'h0800, 16'h0001, 1'b1);
    endtask : windowRuns

    task automatic busTimeout();
        logic ack;
        logic [15:0] d;
        regWrite(`ALS_REG_INTCLR, 16'h000F);
        u_als_i2c_master.startAddr(`ALS_DEV_ADDR, ack);
        u_als_i2c_master.holdScl(1000);
        // Result 0800: first data bit is a zero
        check({15'h0, sdaOeN}, 16'h0000);
        u_als_i2c_master.holdScl(int'(TOUT) * 100 + 10000);
        check({15'h0, sdaOeN}, 16'h0001);
        @(posedge mclk);
        regRead(`ALS_REG_STATUS, d);
        check(d & 16'h0008, 16'h0008);
        u_als_i2c_master.stopCond();
        u_als_i2c_master.readWord(`ALS_DEV_ADDR, ack, d);
        check(d, 16'h0800);
    endtask : busTimeout

    initial begin
        sys_rst = 1'b1;
        regAddr = 3'h0;
        regWrData = 16'h0000;
        regWr = 1'b0;
        regRd = 1'b0;
        adcCode = 16'h1234;
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        resetState();
        fixedRuns();
        autoRuns();
        windowRuns();
        busTimeout();
        endSim();
    end
endmodule : als_ctrl_test
